// [core/mlf_pkg.sv]
// shared constants and types for the motor lock fault configuration block
package mlf_pkg;
	// ****************************************
	// register map (printed offsets are indices)
	// ****************************************
	localparam logic [11:0] IDX_FAULT_SETTINGS_TWO = 12'h092;
	localparam logic [11:0] IDX_LOCK_CTRL          = 12'h093;
	localparam logic [11:0] IDX_LOCK_STATUS        = 12'h094;
	localparam logic [11:0] IDX_LOCK_MASK          = 12'h095;
	localparam logic [11:0] ADDR_FAULT_SETTINGS_TWO = 12'(IDX_FAULT_SETTINGS_TWO * 4);
	localparam logic [11:0] ADDR_LOCK_CTRL          = 12'(IDX_LOCK_CTRL * 4);
	localparam logic [11:0] ADDR_LOCK_STATUS        = 12'(IDX_LOCK_STATUS * 4);
	localparam logic [11:0] ADDR_LOCK_MASK          = 12'(IDX_LOCK_MASK * 4);
	localparam logic [31:0] RESET_FAULT_SETTINGS_TWO = 32'h0000_0000;

	// ****************************************
	// field positions
	// ****************************************
	localparam int POS_RESERVED   = 31;
	localparam int POS_OS_EN      = 30;
	localparam int POS_BEMF_EN    = 29;
	localparam int POS_ABSENT_EN  = 28;
	localparam int POS_OS_THR     = 25;
	localparam int POS_BEMF_THR   = 22;
	localparam int POS_ABSENT_THR = 19;
	localparam int POS_MODE       = 0;
	localparam int POS_RETRY_LIM  = 4;
	localparam int POS_FAULT_CLR  = 8;
	localparam int ST_BITS        = 4;

	// ****************************************
	// threshold encodings
	// ****************************************
	localparam logic [7:0] OS_PCT_BASE      = 8'h82; // 130 percent
	localparam logic [7:0] OS_PCT_STEP      = 8'h0a; // 10 percent
	localparam logic [9:0] BEMF_PM_BASE     = 10'h190; // 40.0 percent in tenths
	localparam logic [9:0] BEMF_PM_STEP     = 10'h032; // 5.0 percent in tenths
	localparam logic [9:0] BEMF_PM_CODE6    = 10'h2a3; // 67.5 percent
	localparam logic [9:0] BEMF_PM_CODE7    = 10'h2bc; // 70.0 percent
	localparam logic [2:0] CODE6            = 3'h6;
	localparam logic [2:0] CODE7            = 3'h7;
	localparam logic [10:0] ABS_MA [8] = '{11'h04b, 11'h04b, 11'h064, 11'h07d,
	                                      11'h0fa, 11'h1f4, 11'h2ee, 11'h3e8};

	// ****************************************
	// lock reaction modes
	// ****************************************
	localparam logic [3:0] MODE_RETRY_FIRST = 4'h4;
	localparam logic [3:0] MODE_REPORT      = 4'h8;
	localparam logic [1:0] DRV_RUN          = 2'h0;
	localparam logic [1:0] DRV_TRISTATE     = 2'h1;
	localparam logic [1:0] DRV_HS_BRAKE     = 2'h2;
	localparam logic [1:0] DRV_LS_BRAKE     = 2'h3;

	typedef struct packed {
		logic       reserved;
		logic       overspeed_lock_enable;
		logic       bemf_lock_enable;
		logic       absent_motor_lock_enable;
		logic [2:0] overspeed_threshold;
		logic [2:0] bemf_threshold;
		logic [2:0] absent_motor_current_threshold;
		logic [18:0] lower;
	} mlf_settings_t;

	typedef struct packed {
		logic [3:0] retry_count_limit;
		logic [3:0] lock_reaction_mode;
	} mlf_ctrl_t;

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_LATCHED = 2'b01,
		ST_RETRY   = 2'b10
	} mlf_state_t;
endpackage

// [core/mlf_top.sv]
// motor lock fault configuration register and lock reaction logic
`timescale 1ns/10ps
module mlf_top #(
	parameter int RETRY_CYCLES = 250000
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// lock detectors in the control core
	input  wire logic        overspeed_trip_i,
	input  wire logic        bemf_trip_i,
	input  wire logic [10:0] phase_current_ma_i,
	// thresholds and reaction
	output logic      [7:0]  overspeed_trip_pct_o,
	output logic      [9:0]  bemf_trip_permille_o,
	output logic      [1:0]  driver_action_o,
	output logic             fault_indicator_pin_n_o,
	output logic             irq_o
);
	// ****************************************
	// registers
	// ****************************************
	mlf_pkg::mlf_settings_t set_r;
	mlf_pkg::mlf_ctrl_t     ctrl_r;
	mlf_pkg::mlf_state_t    state_r, state_nxt;
	logic [mlf_pkg::ST_BITS-1:0] status_r, mask_r;
	logic [31:0] rdata_r;
	logic        ready_r, slverr_r, fault_n_r, irq_r;
	logic [7:0]  os_pct_r;
	logic [9:0]  bemf_pm_r;
	logic [1:0]  drv_r;
	logic [17:0] wait_r;
	logic [3:0]  retries_r;

	// ****************************************
	// bus decode
	// ****************************************
	// one wait state so that read data and pready come from flops
	wire access    = psel_i & penable_i;
	wire commit    = access & ready_r;
	wire wr        = commit & pwrite_i;
	wire rd        = commit & ~pwrite_i;
	wire sel_set   = paddr_i == mlf_pkg::ADDR_FAULT_SETTINGS_TWO;
	wire sel_ctrl  = paddr_i == mlf_pkg::ADDR_LOCK_CTRL;
	wire sel_stat  = paddr_i == mlf_pkg::ADDR_LOCK_STATUS;
	wire sel_mask  = paddr_i == mlf_pkg::ADDR_LOCK_MASK;
	wire mapped    = sel_set | sel_ctrl | sel_stat | sel_mask;
	wire fault_clr = wr & sel_ctrl & pwdata_i[mlf_pkg::POS_FAULT_CLR];
	wire [31:0] rd_mux = sel_set  ? set_r :
	                     sel_ctrl ? {24'h000000, ctrl_r} :
	                     sel_stat ? {28'h0000000, status_r} :
	                     sel_mask ? {28'h0000000, mask_r} : 32'h0000_0000;

	// ****************************************
	// detectors and thresholds
	// ****************************************
	wire [10:0] abs_thr  = mlf_pkg::ABS_MA[set_r.absent_motor_current_threshold];
	wire abs_trip        = phase_current_ma_i < abs_thr;
	wire os_hit          = set_r.overspeed_lock_enable & overspeed_trip_i;
	wire bemf_hit        = set_r.bemf_lock_enable & bemf_trip_i;
	wire abs_hit         = set_r.absent_motor_lock_enable & abs_trip;
	wire any_hit         = os_hit | bemf_hit | abs_hit;
	wire [7:0] os_pct    = mlf_pkg::OS_PCT_BASE
	                     + 8'(set_r.overspeed_threshold * mlf_pkg::OS_PCT_STEP);
	wire [2:0] bc        = set_r.bemf_threshold;
	wire [9:0] bemf_pm   = (bc == mlf_pkg::CODE7) ? mlf_pkg::BEMF_PM_CODE7 :
	                       (bc == mlf_pkg::CODE6) ? mlf_pkg::BEMF_PM_CODE6 :
	                       mlf_pkg::BEMF_PM_BASE + 10'(bc * mlf_pkg::BEMF_PM_STEP);

	// ****************************************
	// lock reaction
	// ****************************************
	wire [3:0] mode      = ctrl_r.lock_reaction_mode;
	wire latch_mode      = mode < mlf_pkg::MODE_RETRY_FIRST;
	wire retry_mode      = ~latch_mode & (mode < mlf_pkg::MODE_REPORT);
	wire report_mode     = mode == mlf_pkg::MODE_REPORT;
	wire wait_done       = wait_r == 18'(RETRY_CYCLES - 1);
	wire retries_spent   = retries_r >= ctrl_r.retry_count_limit;
	// brake kind follows the low two mode bits, codes 0 and 1 both tristate
	wire [1:0] brake     = (mode[1:0] == 2'h0) ? mlf_pkg::DRV_TRISTATE : mode[1:0];
	wire [mlf_pkg::ST_BITS-1:0] events = {state_nxt == mlf_pkg::ST_LATCHED && state_r != mlf_pkg::ST_LATCHED,
	                                      abs_hit, bemf_hit, os_hit};

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			mlf_pkg::ST_RUN: begin
				if (any_hit & latch_mode) begin
					state_nxt = mlf_pkg::ST_LATCHED;
				end else if (any_hit & retry_mode) begin
					state_nxt = retries_spent ? mlf_pkg::ST_LATCHED : mlf_pkg::ST_RETRY;
				end
			end
			mlf_pkg::ST_RETRY: begin
				if (wait_done) begin
					state_nxt = mlf_pkg::ST_RUN;
				end
			end
			mlf_pkg::ST_LATCHED: begin
				if (fault_clr) begin
					state_nxt = mlf_pkg::ST_RUN;
				end
			end
			default: begin
				state_nxt = mlf_pkg::ST_RUN;
			end
		endcase
	end

	wire [1:0] drv_nxt = (state_nxt == mlf_pkg::ST_RUN) ? mlf_pkg::DRV_RUN : brake;
	wire [mlf_pkg::ST_BITS-1:0] status_nxt = (rd & sel_stat ? '0 : status_r) | events; // set wins
	// pin is low while latched, or while a hit stands in report mode
	wire        fault_n_nxt = ~((report_mode & any_hit) | (state_nxt == mlf_pkg::ST_LATCHED));
	wire [17:0] wait_nxt    = (state_r == mlf_pkg::ST_RETRY && !wait_done) ? wait_r + 18'h00001 : 18'h00000;
	wire        retry_start = state_nxt == mlf_pkg::ST_RETRY && state_r == mlf_pkg::ST_RUN;
	// count survives a retry wait, so the next trip can latch once the limit is spent
	wire [3:0]  retries_nxt = retry_start ? retries_r + 4'h1 :
	                          (fault_clr | ~retry_mode) ? 4'h0 : retries_r;

	// ****************************************
	// flops
	// ****************************************
	// bus reply: pready, pslverr and read data all come from flops
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			ready_r  <= 1'b0;
			slverr_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
		end else begin
			ready_r  <= access & ~ready_r;
			slverr_r <= access & ~ready_r & ~mapped;
			rdata_r  <= (access & ~ready_r & ~pwrite_i) ? rd_mux : 32'h0000_0000;
		end
	end

	// software registers
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			set_r <= mlf_pkg::RESET_FAULT_SETTINGS_TWO;
		end else if (wr & sel_set) begin
			set_r <= pwdata_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			ctrl_r <= '0;
		end else if (wr & sel_ctrl) begin
			ctrl_r <= pwdata_i[7:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			mask_r <= '0;
		end else if (wr & sel_mask) begin
			mask_r <= pwdata_i[mlf_pkg::ST_BITS-1:0];
		end
	end

	// sticky status and the level interrupt
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			status_r <= '0;
			irq_r    <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r    <= |(status_nxt & mask_r);
		end
	end

	// reaction state, retry timer and retry count
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			state_r   <= mlf_pkg::ST_RUN;
			wait_r    <= 18'h00000;
			retries_r <= 4'h0;
		end else begin
			state_r   <= state_nxt;
			wait_r    <= wait_nxt;
			retries_r <= retries_nxt;
		end
	end

	// outputs toward the power stage and the core, all from flops so none can glitch
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			fault_n_r <= 1'b1;
			drv_r     <= mlf_pkg::DRV_RUN;
			os_pct_r  <= 8'h00;
			bemf_pm_r <= 10'h000;
		end else begin
			fault_n_r <= fault_n_nxt;
			drv_r     <= drv_nxt;
			os_pct_r  <= os_pct;
			bemf_pm_r <= bemf_pm;
		end
	end

	assign prdata_o                = rdata_r;
	assign pready_o                = ready_r;
	assign pslverr_o               = slverr_r;
	assign overspeed_trip_pct_o    = os_pct_r;
	assign bemf_trip_permille_o    = bemf_pm_r;
	assign driver_action_o         = drv_r;
	assign fault_indicator_pin_n_o = fault_n_r;
	assign irq_o                   = irq_r;
endmodule

// [bench/mlf_chk.sv]
// port-level checks for the lock fault block
`timescale 1ns/10ps
module mlf_chk (
	input wire logic        clock_i,
	input wire logic        nrst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [7:0]  overspeed_trip_pct_o,
	input wire logic [9:0]  bemf_trip_permille_o,
	input wire logic        fault_indicator_pin_n_o,
	input wire logic        irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	function automatic logic [9:0] pm(input logic [2:0] c);
		return (c < 3'h6) ? 10'h190 + 10'h032 * {7'h0, c} : ((c == 3'h6) ? 10'h2a3 : 10'h2bc);
	endfunction
	sequence s_access;
		$rose(penable_i) && psel_i;
	endsequence
	sequence s_set_wr;
		psel_i && penable_i && pready_o && pwrite_i && paddr_i == mlf_pkg::ADDR_FAULT_SETTINGS_TWO;
	endsequence
	chk_ready_wait: assert property (s_access |=> pready_o) else $error("no ready in 2nd access cycle");
	chk_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held");
	chk_ready_cause: assert property (pready_o |-> psel_i && penable_i) else $error("ready without request");
	chk_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error reply");
	chk_idle_data: assert property (!pready_o |-> prdata_o == 32'h0) else $error("data outside reply");
	chk_reset_out: assert property ($rose(nrst_i) |-> fault_indicator_pin_n_o && !irq_o) else $error("bad reset out");
	chk_speed_pct: assert property (s_set_wr |-> ##2
		overspeed_trip_pct_o == 8'h82 + 8'h0a * {5'h0, $past(pwdata_i[27:25], 2)}) else $error("speed pct");
	chk_bemf_pm: assert property (s_set_wr |-> ##2
		bemf_trip_permille_o == pm($past(pwdata_i[24:22], 2))) else $error("bemf permille");
endmodule
bind mlf_top mlf_chk chk_u (.clock_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
	.pready_o, .pslverr_o, .overspeed_trip_pct_o, .bemf_trip_permille_o, .fault_indicator_pin_n_o, .irq_o);

// [bench/mlf_core_model.sv]
// control core stand-in: detector levels and phase current
`timescale 1ns/10ps
module mlf_core_model (
	input  wire logic        clock_i,
	input  wire logic        os_cmd_i,
	input  wire logic        bemf_cmd_i,
	input  wire logic [10:0] ma_cmd_i,
	output logic             overspeed_trip_o,
	output logic             bemf_trip_o,
	output logic      [10:0] phase_current_ma_o
);
	// registered so levels only move after an edge, as from the real core
	always_ff @(posedge clock_i) begin
		overspeed_trip_o   <= os_cmd_i;
		bemf_trip_o        <= bemf_cmd_i;
		phase_current_ma_o <= ma_cmd_i;
	end
endmodule

// [bench/tb_motor_lock_fault_config.sv]
// self-checking bench for the lock fault block
`timescale 1ns/10ps
module tb_motor_lock_fault_config;
	logic        clock_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic        os_t, bemf_t, os_c, bemf_c, pin_n, irq;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [10:0] ma, ma_c;
	logic [7:0]  pct;
	logic [9:0]  pm;
	logic [1:0]  act;
	int          fails, compares;
	mlf_top #(.RETRY_CYCLES(8)) dut_u (.clock_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .overspeed_trip_i(os_t), .bemf_trip_i(bemf_t), .phase_current_ma_i(ma),
		.overspeed_trip_pct_o(pct), .bemf_trip_permille_o(pm), .driver_action_o(act),
		.fault_indicator_pin_n_o(pin_n), .irq_o(irq));
	mlf_core_model core_u (.clock_i, .os_cmd_i(os_c), .bemf_cmd_i(bemf_c), .ma_cmd_i(ma_c),
		.overspeed_trip_o(os_t), .bemf_trip_o(bemf_t), .phase_current_ma_o(ma));
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	task automatic close_out;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		// no cycle count assumed: pready ends the wait, the watchdog ends a hang
		do begin
			@(posedge clock_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic wait_chk(input logic [3:0] exp);
		repeat (4) @(posedge clock_i);
		chk({28'h0, act, pin_n, irq}, {28'h0, exp});
	endtask
	task automatic t_fields;
		logic [31:0] w;
		for (int c = 0; c < 8; c++) begin
			w = {1'b1, 3'h0, 3'(c), 3'(7 - c), 3'(c), 19'h5a5a5};
			apb(1'b1, mlf_pkg::ADDR_FAULT_SETTINGS_TWO, w);
			apb(1'b0, mlf_pkg::ADDR_FAULT_SETTINGS_TWO, 32'h0);
			chk(rd, w);
			chk(32'(pct), 32'(130 + 10 * c));
			chk(32'(pm), (c > 1) ? 32'(750 - 50 * c) : ((c == 1) ? 32'd675 : 32'd700));
		end
	endtask
	task automatic t_lock;
		apb(1'b1, mlf_pkg::ADDR_LOCK_MASK, 32'hf);
		apb(1'b1, mlf_pkg::ADDR_LOCK_CTRL, 32'h2);
		apb(1'b1, mlf_pkg::ADDR_FAULT_SETTINGS_TWO, 32'h4000_0000);
		bemf_c <= 1'b1;
		wait_chk(4'h2);
		bemf_c <= 1'b0;
		os_c <= 1'b1;
		wait_chk(4'h9);
		os_c <= 1'b0;
		apb(1'b0, mlf_pkg::ADDR_LOCK_STATUS, 32'h0);
		chk(rd, 32'h9);
		apb(1'b1, mlf_pkg::ADDR_LOCK_CTRL, 32'h108);
		apb(1'b1, mlf_pkg::ADDR_FAULT_SETTINGS_TWO, 32'h1020_0000);
		ma_c <= 11'd250;
		wait_chk(4'h2);
		ma_c <= 11'd249;
		wait_chk(4'h1);
		ma_c <= 11'd2000;
		wait_chk(4'h3);
		apb(1'b0, mlf_pkg::ADDR_LOCK_STATUS, 32'h0);
		chk(rd, 32'h4);
		wait_chk(4'h2);
	endtask
	task automatic t_retry;
		apb(1'b1, mlf_pkg::ADDR_LOCK_CTRL, 32'h16);
		apb(1'b1, mlf_pkg::ADDR_FAULT_SETTINGS_TWO, 32'h4000_0000);
		os_c <= 1'b1;
		wait_chk(4'hb);
		wait_chk(4'hb);
		wait_chk(4'h9);
		os_c <= 1'b0;
		apb(1'b0, mlf_pkg::ADDR_LOCK_STATUS, 32'h0);
		chk(rd, 32'h9);
		apb(1'b1, mlf_pkg::ADDR_LOCK_CTRL, 32'h109);
		os_c <= 1'b1;
		wait_chk(4'h3);
		os_c <= 1'b0;
		apb(1'b0, mlf_pkg::ADDR_LOCK_STATUS, 32'h0);
		chk(rd, 32'h1);
	endtask
	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i, os_c, bemf_c, fails, compares} = '0;
		paddr_i = 12'h0;
		pwdata_i = 32'h0;
		ma_c = 11'd2000;
		repeat (5) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
		apb(1'b0, mlf_pkg::ADDR_FAULT_SETTINGS_TWO, 32'h0);
		chk(rd, 32'h0);
		chk({30'h0, pin_n, irq}, 32'h2);
		apb(1'b1, 12'h000, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		t_fields();
		t_lock();
		t_retry();
		close_out();
	end
	initial begin
		repeat (5000) @(posedge clock_i);
		fails++;
		close_out();
	end
endmodule
